// *** hw/sdc_delay_cal.sv ***
// SYSREF delay calibration: oscillator trim loop, step storage, delay stages
`timescale 1ns/1ps
`default_nettype none
module sdc_delay_cal #(
   parameter int N_OUT = sdc_pkg::N_SYSREF
) (
   // Clock and power-on reset
   input  wire logic                                   ref_clk,
   input  wire logic                                   nrst,

   // Software control
   input  wire logic                                   calibrate_start_wr,
   input  wire logic [sdc_pkg::MULT_W-1:0]             step_multiplier,
   input  wire logic [sdc_pkg::DIV_W-1:0]              cal_prediv,
   input  wire logic [sdc_pkg::DIV_W-1:0]              cal_feedback_div,

   // Phase delay settings
   input  wire logic [7:0]                             clk_delay_code,
   input  wire logic [N_OUT-1:0][sdc_pkg::DLY_W-1:0]   sysref_delay_code,

   // Internal oscillator front end
   input  wire logic                                   osc_tick,
   output logic                                        osc_enable,
   output logic                                        cal_div_enable,
   output logic [sdc_pkg::CODE_W-1:0]                  osc_tune,

   // Status readback
   output logic                                        calibrate_start,
   output logic                                        cal_busy,
   output logic [sdc_pkg::CODE_W-1:0]                  dac_code,
   output logic                                        cal_ok,
   output logic                                        step_valid,
   output logic [sdc_pkg::PS_W-1:0]                    delay_step_ps,

   // SYSREF delay stages
   output logic [N_OUT-1:0][sdc_pkg::PS_W-1:0]         sysref_delay_ps,
   output logic [N_OUT-1:0]                            sysref_leads
);
   import sdc_pkg::*;

   // ==========================================================================
   // Elaboration checks
   if (N_OUT < 1 || N_OUT > 16) begin : g_chk_n
      $error("sdc_delay_cal: output count out of range");
   end
   if (SETTLE_CYC < 1) begin : g_chk_settle
      $error("sdc_delay_cal: settle time rounds below one cycle");
   end

   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

   // ==========================================================================
   // Declarations
   sdc_state_t        state_q;
   sdc_state_t        state_d;
   logic [7:0]        settle_q;
   logic [CODE_W-1:0] trial_q;
   logic [CODE_W-1:0] bit_q;
   logic              start_q;
   logic              pend_q;
   logic              run_q;
   logic              cmp_start_q;
   logic [1:0]        osc_sync_q;
   logic              osc_prev_q;
   logic              fb_tick;
   sdc_cmp_if         cif ();

   // ==========================================================================
   // Oscillator tick synchroniser
   // The front-end toggles osc_tick asynchronously; two flops before the edge
   // detector keep metastability out of the comparator.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         osc_sync_q <= 2'b00;
         osc_prev_q <= 1'b0;
      end else begin
         osc_sync_q <= {osc_sync_q[0], osc_tick};
         osc_prev_q <= osc_sync_q[1];
      end
   end

   wire osc_edge = run_q && (osc_sync_q[1] != osc_prev_q);

   // ==========================================================================
   // Calibration dividers
   // Pre-divider on the device input clock gives f1, the lock reference.
   sdc_div #(.W(DIV_W)) u_prediv (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .run      (run_q),
      .ratio    (cal_prediv),
      .tick_in  (1'b1),
      .tick_out (cif.f1_tick)
   );

   // Feedback divider on the oscillator path
   sdc_div #(.W(DIV_W)) u_fbdiv (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .run      (run_q),
      .ratio    (cal_feedback_div),
      .tick_in  (osc_edge),
      .tick_out (fb_tick)
   );

   // Step divider follows the multiplier code: 00 gives 1, 11 gives 4
   wire [DIV_W-1:0] step_ratio = DIV_W'(step_multiplier) + 1'b1;

   sdc_div #(.W(DIV_W)) u_stepdiv (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .run      (run_q),
      .ratio    (step_ratio),
      .tick_in  (fb_tick),
      .tick_out (cif.f2_tick)
   );

   // ==========================================================================
   // Frequency comparator
   assign cif.start = cmp_start_q;

   sdc_freq_cmp u_cmp (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .cif     (cif)
   );

   // ==========================================================================
   // Sequencer decode
   wire settle_done = (settle_q == SETTLE_LAST);
   wire last_bit    = bit_q[0];
   wire [CODE_W-1:0] trial_keep = cif.osc_fast ? (trial_q & ~bit_q) : trial_q;
   wire [CODE_W-1:0] trial_next = trial_keep | (bit_q >> 1);
   wire code_ok = (trial_keep != CODE_MIN) && (trial_keep != CODE_MAX);

   // Captured step: one eighth of the locked oscillator period per unit,
   // scaled by the multiplier. Lock makes the period nominal, so the unit is
   // the nominal figure.
   wire [PS_W-1:0] step_meas = PS_W'(UNIT_PS * (step_multiplier + 3'h1));

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         SDC_IDLE:    if (start_q) state_d = SDC_SETTLE;
         SDC_SETTLE:  if (settle_done) state_d = SDC_MEASURE;
         SDC_MEASURE: if (cif.done) state_d = SDC_DECIDE;
         SDC_DECIDE:  state_d = last_bit ? SDC_STORE : SDC_SETTLE;
         SDC_STORE:   state_d = SDC_IDLE;
         default:     state_d = SDC_IDLE;
      endcase
   end

   // ==========================================================================
   // State register and settle timer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= SDC_IDLE;
         settle_q <= '0;
      end else begin
         state_q  <= state_d;
         settle_q <= (state_q == SDC_SETTLE) ? settle_q + 1'b1 : '0;
      end
   end

   // ==========================================================================
   // Start bit
   // A write during a run is held pending and relaunches after completion;
   // a write in the completion cycle wins over the self-clear.
   wire start_d = calibrate_start_wr || pend_q || (start_q && state_q != SDC_STORE);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         start_q <= 1'b0;
         pend_q  <= 1'b0;
      end else begin
         start_q <= start_d;
         pend_q  <= (state_q != SDC_STORE) && (pend_q || (calibrate_start_wr && start_q));
      end
   end

   // ==========================================================================
   // Successive approximation of the oscillator control code
   // Each trial bit is kept unless the divided oscillator outran the
   // reference, which converges on f1 = f2 within the tuning range.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         trial_q <= '0;
         bit_q   <= '0;
      end else if (state_q == SDC_IDLE && start_q) begin
         trial_q <= CODE_MSB;
         bit_q   <= CODE_MSB;
      end else if (state_q == SDC_DECIDE) begin
         trial_q <= last_bit ? trial_keep : trial_next;
         bit_q   <= bit_q >> 1;
      end
   end

   // Comparison window launch, one pulse when settling ends
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         cmp_start_q <= 1'b0;
      else
         cmp_start_q <= (state_q == SDC_SETTLE) && settle_done;
   end

   // ==========================================================================
   // Power control of oscillator and dividers
   // Everything in the loop runs only during a calibration; afterwards it is
   // off to save power and to keep its tones out of the SYSREF paths.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_q          <= 1'b0;
         osc_enable     <= 1'b0;
         cal_div_enable <= 1'b0;
      end else if (state_q == SDC_IDLE && start_q) begin
         run_q          <= 1'b1;
         osc_enable     <= 1'b1;
         cal_div_enable <= 1'b1;
      end else if (state_q == SDC_STORE) begin
         run_q          <= 1'b0;
         osc_enable     <= 1'b0;
         cal_div_enable <= 1'b0;
      end
   end

   // Oscillator tune word follows the trial code while the loop runs
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         osc_tune <= '0;
      else if (state_q == SDC_DECIDE || (state_q == SDC_IDLE && start_q))
         osc_tune <= (state_q == SDC_IDLE) ? CODE_MSB :
                     (last_bit ? trial_keep : trial_next);
   end

   // ==========================================================================
   // Status readback
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         calibrate_start <= 1'b0;
         cal_busy        <= 1'b0;
      end else begin
         calibrate_start <= start_d;
         cal_busy        <= (state_d != SDC_IDLE);
      end
   end

   // ==========================================================================
   // Stored delay step
   // Only power-on reset and a completed run touch these; the old step stays
   // in force for the whole of a run, so SYSREF delays never glitch mid-run.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dac_code      <= CODE_MIN;
         cal_ok        <= 1'b0;
         step_valid    <= 1'b0;
         delay_step_ps <= STEP_RST;
      end else if (state_q == SDC_DECIDE && last_bit) begin
         dac_code      <= trial_keep;
         cal_ok        <= code_ok;
         step_valid    <= 1'b1;
         delay_step_ps <= step_meas;
      end
   end

   // ==========================================================================
   // SYSREF delay stages
   // Each stage scales its code by the stored step only, so the delay does
   // not move with clock or SYSREF frequency. Codes 0..7 give eight steps.
   wire clk_delay_zero = (clk_delay_code == CLK_DLY_0);

   for (genvar r = 0; r < N_OUT; r++) begin : g_stage
      wire [PS_W-1:0] dly = PS_W'(sysref_delay_code[r] * delay_step_ps);
      wire            lead = clk_delay_zero && (sysref_delay_code[r] <= LEAD_MAX);

      // Registered so every output leaves a flop
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            sysref_delay_ps[r] <= '0;
            sysref_leads[r]    <= 1'b0;
         end else begin
            sysref_delay_ps[r] <= dly;
            sysref_leads[r]    <= lead;
         end
      end
   end

endmodule : sdc_delay_cal
`default_nettype wire

// *** pkg/sdc_pkg.sv ***
// Constants and types shared by the SYSREF delay calibration block
// ==========================================================================
// Operation
// - Multiplier code selects x1..x4 and step divider
// - Step is one eighth oscillator period times multiplier
// - Start bit launches calibration, self-clears when done
// - Measured step captured digitally at calibration end
// - Oscillator and three dividers powered down afterwards
// - Delay stages use stored step, not oscillator
// - Stored step persists until power is removed
// - Readable control code; inside 0..32767 exclusive succeeds
// - Oscillator locks within twenty megahertz of nominal
// - Device input clock is the lock reference
// - SYSREF code three or less leads the clock when clock delay code is zero
// - Delays independent of clock and SYSREF frequency
// - At least eight SYSREF delay steps provided
package sdc_pkg;

   // ==========================================================================
   // Widths
   localparam int CODE_W      = 15;              // Oscillator control code
   localparam int MULT_W      = 2;               // Step multiplier field
   localparam int DIV_W       = 8;               // Pre-divider and feedback divider
   localparam int DLY_W       = 3;               // SYSREF delay code per output
   localparam int PS_W        = 12;              // Delay in picoseconds
   localparam int WIN_W       = 16;              // Comparison window counters
   localparam int N_SYSREF    = 8;               // SYSREF outputs with delay stages

   // ==========================================================================
   // Code limits and reset values
   localparam logic [CODE_W-1:0] CODE_MIN   = 15'h0000;
   localparam logic [CODE_W-1:0] CODE_MAX   = 15'h7fff;
   localparam logic [CODE_W-1:0] CODE_MSB   = 15'h4000;   // First trial bit
   localparam logic [PS_W-1:0]   STEP_RST   = 12'h083;    // 131 ps before any calibration
   localparam logic [PS_W-1:0]   UNIT_PS    = 12'h083;    // 131 ps per multiplier unit
   localparam logic [DLY_W-1:0]  LEAD_MAX   = 3'h3;       // Codes up to this lead the clock when clock delay code is zero
   localparam logic [7:0]        CLK_DLY_0  = 8'h00;

   // ==========================================================================
   // Timing
   localparam int CLK_MHZ     = 25;              // ref_clk rate
   localparam int SETTLE_US   = 2;               // Oscillator settling after each trim step
   localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
   localparam int WIN_TICKS   = 64;              // Reference ticks per comparison window

   // ==========================================================================
   // Calibration sequencer states
   typedef enum logic [2:0] {
      SDC_IDLE,
      SDC_SETTLE,
      SDC_MEASURE,
      SDC_DECIDE,
      SDC_STORE
   } sdc_state_t;

endpackage : sdc_pkg

// *** pkg/sdc_cmp_if.sv ***
// Interface between the calibration sequencer and the frequency comparator
`timescale 1ns/1ps
`default_nettype none
interface sdc_cmp_if;
   logic start;      // Begin one comparison window
   logic f1_tick;    // Divided reference tick
   logic f2_tick;    // Divided oscillator tick
   logic done;       // Window finished, pulse
   logic osc_fast;   // Oscillator side counted more ticks

   modport ctrl (output start, output f1_tick, output f2_tick,
                 input done, input osc_fast);
   modport cmp  (input start, input f1_tick, input f2_tick,
                 output done, output osc_fast);
endinterface : sdc_cmp_if
`default_nettype wire

// *** hw/sdc_div.sv ***
// Enable-based programmable divider for the calibration chain
`timescale 1ns/1ps
`default_nettype none
module sdc_div #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // Control
   input  wire logic         run,
   input  wire logic [W-1:0] ratio,
   // Ticks
   input  wire logic         tick_in,
   output logic              tick_out
);
   logic [W-1:0] cnt_q;
   wire  [W-1:0] last = (ratio == '0) ? '0 : ratio - 1'b1;   // Ratio 0 behaves as 1
   wire          wrap = tick_in && (cnt_q >= last);

   if (W < 1) begin : g_chk
      $error("sdc_div: width must be at least one");
   end

   // Counter held clear while powered down
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q    <= '0;
         tick_out <= 1'b0;
      end else if (!run) begin
         cnt_q    <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= wrap;
         if (wrap)
            cnt_q <= '0;
         else if (tick_in)
            cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : sdc_div
`default_nettype wire

// *** hw/sdc_freq_cmp.sv ***
// Frequency comparator: counts both divided ticks over a fixed window
`timescale 1ns/1ps
`default_nettype none
module sdc_freq_cmp
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   // Sequencer side
   sdc_cmp_if.cmp    cif
);
   localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_TICKS - 1);

   logic             busy_q;
   logic [WIN_W-1:0] f1_cnt_q;
   logic [WIN_W-1:0] f2_cnt_q;
   wire              f2_sat = &f2_cnt_q;
   wire              win_end = busy_q && cif.f1_tick && (f1_cnt_q == WIN_LAST);

   if (WIN_TICKS < 2 || WIN_TICKS > 32768) begin : g_chk
      $error("sdc_freq_cmp: window length out of range");
   end

   // Window counting; f2 saturates so a runaway oscillator still reads as fast
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         busy_q       <= 1'b0;
         f1_cnt_q     <= '0;
         f2_cnt_q     <= '0;
         cif.done     <= 1'b0;
         cif.osc_fast <= 1'b0;
      end else begin
         cif.done <= win_end;
         if (cif.start) begin
            busy_q   <= 1'b1;
            f1_cnt_q <= '0;
            f2_cnt_q <= '0;
         end else if (busy_q) begin
            if (cif.f1_tick)
               f1_cnt_q <= f1_cnt_q + 1'b1;
            if (cif.f2_tick && !f2_sat)
               f2_cnt_q <= f2_cnt_q + 1'b1;
            if (win_end) begin
               busy_q       <= 1'b0;
               cif.osc_fast <= (f2_cnt_q + WIN_W'(cif.f2_tick)) > WIN_LAST + 1'b1;
            end
         end
      end
   end
endmodule : sdc_freq_cmp
`default_nettype wire

// *** verification/sdc_osc_model.sv ***
// Behavioural model of the internal oscillator that drives the tick line
`timescale 1ns/1ps
`default_nettype none
module sdc_osc_model (
   // Power and trim
   input  wire logic                      enable,
   input  wire logic [sdc_pkg::CODE_W-1:0] tune,
   // Tick line
   output logic                           tick
);
   import sdc_pkg::*;
   // ==========================================================================
   // Oscillator
   // Higher trim shortens the toggle interval; powered down, the line stands still
   initial tick = 1'b0;
   always begin
      if (enable) begin
         #(320.0 - real'(tune) / 128.0);
         if (enable) tick = ~tick;
      end else begin
         @(posedge enable);
      end
   end
endmodule // sdc_osc_model
`default_nettype wire

// *** verification/sdc_delay_cal_asserts.sv ***
// Concurrent checks on the ports of the SYSREF delay calibration block
`timescale 1ns/1ps
`default_nettype none
module sdc_delay_cal_asserts #(
   parameter int N_OUT = sdc_pkg::N_SYSREF
) (
   // Clock and reset
   input  wire logic                                 ref_clk,
   input  wire logic                                 nrst,
   // Software control
   input  wire logic                                 calibrate_start_wr,
   input  wire logic [sdc_pkg::MULT_W-1:0]           step_multiplier,
   input  wire logic [7:0]                           clk_delay_code,
   input  wire logic [N_OUT-1:0][sdc_pkg::DLY_W-1:0] sysref_delay_code,
   // Outputs watched
   input  wire logic                                 osc_enable,
   input  wire logic                                 cal_div_enable,
   input  wire logic [sdc_pkg::CODE_W-1:0]           osc_tune,
   input  wire logic                                 calibrate_start,
   input  wire logic                                 cal_busy,
   input  wire logic [sdc_pkg::CODE_W-1:0]           dac_code,
   input  wire logic                                 cal_ok,
   input  wire logic                                 step_valid,
   input  wire logic [sdc_pkg::PS_W-1:0]             delay_step_ps,
   input  wire logic [N_OUT-1:0][sdc_pkg::PS_W-1:0]  sysref_delay_ps,
   input  wire logic [N_OUT-1:0]                     sysref_leads
);
   import sdc_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ==========================================================================
   // Start bit and sequencing
   start_answer_a : assert property (calibrate_start_wr |=> calibrate_start)
      else $error("start bit not set after write");
   run_begin_a : assert property (calibrate_start_wr && !cal_busy && !calibrate_start
      |-> ##2 (cal_busy && osc_enable && cal_div_enable && osc_tune == CODE_MSB))
      else $error("run did not begin two cycles after write");
   start_clear_a : assert property ($fell(calibrate_start) |-> ##[0:1] !cal_busy)
      else $error("start bit cleared before completion");
   rerun_merge_a : assert property ($fell(cal_busy) && calibrate_start |-> ##[1:3] cal_busy)
      else $error("merged start did not rerun");
   power_down_a : assert property ($fell(cal_busy)
      |-> ##[0:1] (!osc_enable && !cal_div_enable))
      else $error("oscillator or dividers left powered");
   // ==========================================================================
   // Stored step; it may move only at the capture edge of a run
   step_hold_a : assert property (!osc_enable |=> $stable(delay_step_ps))
      else $error("stored step changed outside a run");
   step_value_a : assert property ($changed(delay_step_ps)
      |-> delay_step_ps == UNIT_PS * ({10'h000, step_multiplier} + 12'h001))
      else $error("captured step wrong for multiplier");
   valid_sticky_a : assert property (step_valid |=> step_valid)
      else $error("step valid dropped");
   code_ok_a : assert property (cal_ok == (dac_code != CODE_MIN && dac_code != CODE_MAX))
      else $error("success flag disagrees with code");
   // ==========================================================================
   // Delay stages follow inputs and stored step one cycle later
   for (genvar r = 0; r < N_OUT; r++) begin : g_stage
      stage_value_a : assert property ($past(nrst) |-> sysref_delay_ps[r] ==
         $past(sysref_delay_code[r]) * $past(delay_step_ps))
         else $error("stage delay wrong");
      stage_lead_a : assert property ($past(nrst) |-> sysref_leads[r] ==
         ($past(clk_delay_code) == 8'h00 && $past(sysref_delay_code[r]) <= LEAD_MAX))
         else $error("lead flag wrong");
   end
endmodule // sdc_delay_cal_asserts

bind sdc_delay_cal sdc_delay_cal_asserts #(.N_OUT(N_OUT)) u_asserts (
   .ref_clk(ref_clk), .nrst(nrst), .calibrate_start_wr(calibrate_start_wr),
   .step_multiplier(step_multiplier), .clk_delay_code(clk_delay_code),
   .sysref_delay_code(sysref_delay_code), .osc_enable(osc_enable),
   .cal_div_enable(cal_div_enable), .osc_tune(osc_tune), .calibrate_start(calibrate_start),
   .cal_busy(cal_busy), .dac_code(dac_code), .cal_ok(cal_ok), .step_valid(step_valid),
   .delay_step_ps(delay_step_ps), .sysref_delay_ps(sysref_delay_ps),
   .sysref_leads(sysref_leads));
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the SYSREF delay calibration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sdc_pkg::*;
   logic                           ref_clk = 1'b0;
   logic                           nrst = 1'b0;
   logic                           calibrate_start_wr = 1'b0;
   logic [MULT_W-1:0]              step_multiplier = 2'h0;
   logic [DIV_W-1:0]               cal_prediv = 8'h08;
   logic [DIV_W-1:0]               cal_feedback_div = 8'h02;
   logic [7:0]                     clk_delay_code = 8'h01;
   logic [N_SYSREF-1:0][DLY_W-1:0] sysref_delay_code = '0;
   logic                           osc_tick, osc_enable, cal_div_enable, calibrate_start;
   logic                           cal_busy, cal_ok, step_valid;
   logic [CODE_W-1:0]              osc_tune, dac_code;
   logic [PS_W-1:0]                delay_step_ps;
   logic [N_SYSREF-1:0][PS_W-1:0]  sysref_delay_ps;
   logic [N_SYSREF-1:0]            sysref_leads;
   int                             errors = 0;
   int                             tests_run = 0;
   int                             cycles = 0;
   int                             target [4] = '{20480, 20480, 27307, 30720};

   always #20 ref_clk = ~ref_clk;

   sdc_delay_cal u_dut (.ref_clk(ref_clk), .nrst(nrst), .calibrate_start_wr(calibrate_start_wr),
      .step_multiplier(step_multiplier), .cal_prediv(cal_prediv),
      .cal_feedback_div(cal_feedback_div), .clk_delay_code(clk_delay_code),
      .sysref_delay_code(sysref_delay_code), .osc_tick(osc_tick), .osc_enable(osc_enable),
      .cal_div_enable(cal_div_enable), .osc_tune(osc_tune), .calibrate_start(calibrate_start),
      .cal_busy(cal_busy), .dac_code(dac_code), .cal_ok(cal_ok), .step_valid(step_valid),
      .delay_step_ps(delay_step_ps), .sysref_delay_ps(sysref_delay_ps),
      .sysref_leads(sysref_leads));
   sdc_osc_model u_osc (.enable(osc_enable), .tune(osc_tune), .tick(osc_tick));

   // ==========================================================================
   // Compare tasks, verdict and hang guard
   task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Ceiling covers seven runs of about 8.5k cycles each, with margin
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         $display("CHECK FAILED t=%0t run hung", $time);
         finish_test();
      end
   end

   // ==========================================================================
   // Access tasks: start pulse and bounded wait for completion
   task automatic wait_idle;
      int n;
      n = 0;
      while (cal_busy !== 1'b0 && n < 20000) begin
         @(negedge ref_clk);
         n++;
      end
      chk_eq(n < 20000, 1);
   endtask
   task automatic calib(input logic [1:0] m, input logic [7:0] fb, input bit again);
      logic [PS_W-1:0] old;
      old = delay_step_ps;
      @(negedge ref_clk);
      step_multiplier = m;
      cal_feedback_div = fb;
      calibrate_start_wr = 1'b1;
      @(negedge ref_clk);
      calibrate_start_wr = 1'b0;
      chk_eq(calibrate_start, 1'b1);
      @(negedge ref_clk);
      chk_eq({cal_busy, osc_enable, cal_div_enable}, 3'h7);
      repeat (1000) @(negedge ref_clk);
      chk_eq(delay_step_ps, old);
      calibrate_start_wr = again;
      @(negedge ref_clk);
      calibrate_start_wr = 1'b0;
      wait_idle();
      if (again) begin
         chk_eq(calibrate_start, 1'b1);
         repeat (3) @(negedge ref_clk);
         chk_eq(cal_busy, 1'b1);
         wait_idle();
      end
      @(negedge ref_clk);
      chk_eq({calibrate_start, osc_enable, cal_div_enable}, 3'h0);
      chk_eq(delay_step_ps, 16'd131 * (m + 16'd1));
      chk_eq(step_valid, 1'b1);
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      chk_eq(delay_step_ps, 16'h0083);
      chk_eq({cal_busy, step_valid, cal_ok, dac_code}, 16'h0000);
      $display("test reset done");
      // Each multiplier with dividers that keep the loop lockable
      for (int m = 0; m < 4; m++) begin
         calib(m[1:0], (m == 0) ? 8'h02 : 8'h01, 1'b0);
         chk_eq(cal_ok, 1'b1);
         chk_rng(dac_code, target[m] - 1024, target[m] + 1024);
      end
      $display("test multipliers done");
      // Field change without a run leaves the stored step alone
      step_multiplier = 2'h0;
      repeat (4) @(negedge ref_clk);
      chk_eq(delay_step_ps, 16'd524);
      // Every code on its own output, clock delay zero then nonzero
      clk_delay_code = 8'h00;
      for (int r = 0; r < N_SYSREF; r++) sysref_delay_code[r] = r[2:0];
      repeat (2) @(negedge ref_clk);
      for (int r = 0; r < N_SYSREF; r++) begin
         chk_eq(sysref_delay_ps[r], 16'd524 * r[15:0]);
         chk_eq(sysref_leads[r], r <= 3);
      end
      clk_delay_code = 8'h10;
      repeat (2) @(negedge ref_clk);
      chk_eq(sysref_leads, 8'h00);
      $display("test delay stages done");
      // Second write in mid-run is merged into a following run
      calib(2'h3, 8'h01, 1'b1);
      $display("test merged start done");
      // Only a power cycle clears the stored step
      nrst = 1'b0;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      chk_eq({step_valid, delay_step_ps}, 16'h0083);
      // Unlockable divider set pins the code at full scale
      calib(2'h0, 8'h08, 1'b0);
      chk_eq({cal_ok, dac_code}, 16'h7fff);
      $display("test failed lock done");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
